// ---- logic/trigger_capture_pkg.sv ----
// Purpose: constants and types for the trigger position capture unit
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes on behaviour
// - with source 0 or 3, a selected trigger latches the encoder counter in hardware at once
// - capture source 0, the reset value, means hardware capture, input trigger
// - trigger latch holds 24 whole-count bits over 8 fraction bits
// - timer extension mode 0 puts a timer estimate in the 8 fraction bits
// - timer extension mode above zero makes the fraction read one half
// - mode 0 also fills a fine latch, 20 whole bits, 12 fraction bits
// - fine fraction comes from timers; servo fraction from arctangent if enabled
// - sources 1 and 2 are software capture; no counter latch is taken
// - software capture may lag by realtime period plus one servo interrupts
// - source 3 latches the timer at trigger and at each servo interrupt
// - pulse generator adds a 32-bit command per pulse clock, pulses on carry
// - pulse clock divider resets to 5, giving 3.125 MHz
// - counter input select 8 counts internal pulses, ignoring encoder inputs
// - a stored pulse-rate command loads into the active register after reset
// - trigger is built from edge select, flag select and flag channel
// - capture responds to a rising edge of the trigger, never a level
// - the position-captured indication is bit 20 of channel status
package trigger_capture_pkg;

  // clock and pulse-clock timing
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned PULSE_CLK_HZ_DEFAULT = 3125000;
  localparam int unsigned DIV_CYCLES_DEFAULT = CLK_HZ / PULSE_CLK_HZ_DEFAULT;
  localparam logic [2:0] PULSE_DIV_RESET = 3'h5;
  localparam int unsigned DIV_STEP = DIV_CYCLES_DEFAULT / 5;
  localparam logic [5:0] DIV_STEP_W = 6'(DIV_STEP);

  // capture source settings
  localparam logic [1:0] SRC_HW = 2'h0;
  localparam logic [1:0] SRC_SW_INPUT = 2'h1;
  localparam logic [1:0] SRC_SW_ERROR = 2'h2;
  localparam logic [1:0] SRC_TIMER_SW = 2'h3;

  // counter input select value that routes the internal pulse train
  localparam logic [3:0] CNT_SEL_PULSE = 4'h8;

  // trigger edge select field positions
  localparam int unsigned EDGE_USE_INDEX = 0;
  localparam int unsigned EDGE_USE_FLAG = 1;
  localparam int unsigned EDGE_INDEX_LOW = 2;
  localparam int unsigned EDGE_FLAG_LOW = 3;

  // register layouts and status bit
  localparam int unsigned LATCH_FRAC_BITS = 8;
  localparam int unsigned FINE_FRAC_BITS = 12;
  localparam int unsigned STATUS_CAPTURED_BIT = 20;
  localparam logic [7:0] HALF_COUNT_FRAC = 8'h80;
  localparam logic [31:0] PULSE_RATE_RESET = 32'h00000000;
  localparam logic [15:0] TIMER_MAX = 16'hFFFF;

  // channel configuration settings
  typedef struct packed {
    logic [1:0] capture_source_select;
    logic [1:0] timer_extension_mode;
    logic arctangent_enable;
    logic [3:0] counter_input_select;
    logic [3:0] trigger_edge_select;
    logic [1:0] trigger_flag_select;
    logic [1:0] trigger_flag_channel;
    logic [7:0] realtime_interrupt_period;
  } capture_cfg_t;

endpackage : trigger_capture_pkg

// ---- logic/trigger_position_capture.sv ----
// Purpose: servo channel counter with trigger capture and pulse generator
// Assumes: all inputs synchronous to clk; flags are four channels of four
// Notes: capture latch is re-armed by a read strobe from firmware
`timescale 1ns/1ns
module trigger_position_capture (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration settings
  input wire trigger_capture_pkg::capture_cfg_t cfg,
  // pulse clock divider register
  input wire logic div_we,
  input wire logic [2:0] div_wdata,
  output logic [2:0] pulse_clock_divider,
  // pulse rate command register and stored copy
  input wire logic pulse_rate_we,
  input wire logic [31:0] pulse_rate_wdata,
  input wire logic nv_valid,
  input wire logic [31:0] nv_pulse_rate,
  output logic [31:0] pulse_rate_command,
  // encoder and flag inputs
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_index,
  input wire logic [15:0] flags,
  input wire logic [11:0] atan_frac,
  // servo interrupt
  input wire logic servo_int,
  // capture registers and status
  input wire logic latch_read,
  output logic [31:0] trigger_position_latch,
  output logic [31:0] fine_trigger_capture,
  output logic [31:0] servo_position,
  output logic [15:0] trigger_timer,
  output logic [15:0] servo_timer,
  output logic [31:0] channel_status,
  output logic sw_capture_overdue,
  output logic pulse_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // fraction of a count elapsed, in 4096ths, saturating below one count
  function automatic logic [11:0] frac12(input logic [15:0] num,
                                         input logic [15:0] den);
    logic [16:0] rem;
    logic [11:0] q;
    rem = 17'h00000;
    q = 12'h000;
    if (den == 16'h0000) begin
      q = 12'h000;
    end else if (num >= den) begin
      q = 12'hFFF;
    end else begin
      rem = {1'b0, num};
      for (int i = 11; i >= 0; i--) begin
        rem = {rem[15:0], 1'b0};
        if (rem >= {1'b0, den}) begin
          rem = rem - {1'b0, den};
          q[i] = 1'b1;
        end
      end
    end
    return q;
  endfunction : frac12

  // rising edge from a present and a previous level
  function automatic logic rose(input logic now, input logic prev);
    return now & ~prev;
  endfunction : rose

  ////////////////////////////////////////////////////////////////////////////
  // pulse clock and pulse generator

  logic [2:0] div_r;
  logic [5:0] div_cnt_r;
  logic [5:0] div_limit;
  logic tick;
  logic [31:0] rate_r;
  logic load_pending_r;
  logic [31:0] acc_r;
  logic [32:0] acc_sum;
  logic pulse_r;

  // divider setting register, resets to its default
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= trigger_capture_pkg::PULSE_DIV_RESET;
    end else if (div_we) begin
      div_r <= div_wdata;
    end
  end

  // cycles per pulse clock tick; setting 0 acts as 1
  always_comb begin
    if (div_r == 3'h0) begin
      div_limit = trigger_capture_pkg::DIV_STEP_W;
    end else begin
      div_limit = 6'(trigger_capture_pkg::DIV_STEP_W * div_r);
    end
  end

  // pulse clock tick generator
  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_r <= 6'h00;
    end else if (div_cnt_r >= div_limit - 6'h01) begin
      div_cnt_r <= 6'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 6'h01;
    end
  end
  assign tick = (div_cnt_r >= div_limit - 6'h01);

  // active command register, stored copy loaded after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_r <= trigger_capture_pkg::PULSE_RATE_RESET;
      load_pending_r <= 1'b1;
    end else if (pulse_rate_we) begin
      rate_r <= pulse_rate_wdata;
      load_pending_r <= 1'b0;
    end else if (load_pending_r) begin
      if (nv_valid) begin
        rate_r <= nv_pulse_rate;
      end
      load_pending_r <= 1'b0;
    end
  end

  // accumulator, carry out is one pulse
  assign acc_sum = {1'b0, acc_r} + {1'b0, rate_r};
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r <= 32'h00000000;
      pulse_r <= 1'b0;
    end else if (tick) begin
      acc_r <= acc_sum[31:0];
      pulse_r <= acc_sum[32];
    end else begin
      pulse_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel counter and interval timer

  logic a_prev_r;
  logic b_prev_r;
  logic use_pulse;
  logic step;
  logic up;
  logic [23:0] count_r;
  logic [15:0] elapsed_r;
  logic [15:0] period_r;
  logic [11:0] now_frac;

  assign use_pulse = (cfg.counter_input_select ==
                      trigger_capture_pkg::CNT_SEL_PULSE);

  // encoder inputs are ignored while the pulse train is selected
  always_comb begin
    if (use_pulse) begin
      step = pulse_r;
      up = 1'b1;
    end else begin
      step = (enc_a ^ a_prev_r) | (enc_b ^ b_prev_r);
      up = a_prev_r ^ enc_b;
    end
  end

  // quadrature history
  always_ff @(posedge clk) begin
    if (rst) begin
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
    end else begin
      a_prev_r <= enc_a;
      b_prev_r <= enc_b;
    end
  end

  // whole-count counter
  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= 24'h000000;
    end else if (step) begin
      count_r <= up ? count_r + 24'h000001 : count_r - 24'h000001;
    end
  end

  // time since last count and length of last count interval
  always_ff @(posedge clk) begin
    if (rst) begin
      elapsed_r <= 16'h0000;
      period_r <= 16'h0000;
    end else if (step) begin
      elapsed_r <= 16'h0000;
      period_r <= elapsed_r;
    end else if (elapsed_r != trigger_capture_pkg::TIMER_MAX) begin
      elapsed_r <= elapsed_r + 16'h0001;
    end
  end

  assign now_frac = frac12(elapsed_r, period_r);

  ////////////////////////////////////////////////////////////////////////////
  // trigger selection and edge detection

  logic flag_bit;
  logic index_bit;
  logic trig_level;
  logic trig_prev_r;
  logic trig_edge;

  // pick flag by channel and select, apply polarities
  always_comb begin
    flag_bit = flags[{cfg.trigger_flag_channel, cfg.trigger_flag_select}] ^
               cfg.trigger_edge_select[trigger_capture_pkg::EDGE_FLAG_LOW];
    index_bit = enc_index ^
                cfg.trigger_edge_select[trigger_capture_pkg::EDGE_INDEX_LOW];
    if (cfg.trigger_edge_select[trigger_capture_pkg::EDGE_USE_FLAG] &&
        cfg.trigger_edge_select[trigger_capture_pkg::EDGE_USE_INDEX]) begin
      trig_level = flag_bit & index_bit;
    end else if (cfg.trigger_edge_select[
                 trigger_capture_pkg::EDGE_USE_FLAG]) begin
      trig_level = flag_bit;
    end else if (cfg.trigger_edge_select[
                 trigger_capture_pkg::EDGE_USE_INDEX]) begin
      trig_level = index_bit;
    end else begin
      trig_level = 1'b0;
    end
  end

  // edge memory; reset assumes the trigger state so no false capture
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_prev_r <= 1'b1;
    end else begin
      trig_prev_r <= trig_level;
    end
  end
  assign trig_edge = rose(trig_level, trig_prev_r);

  ////////////////////////////////////////////////////////////////////////////
  // capture latches and status

  logic captured_r;
  logic hw_latch;
  logic timer_latch;
  logic [31:0] latch_r;
  logic [31:0] fine_r;
  logic [15:0] trig_timer_r;
  logic servo_prev_r;
  logic servo_edge;
  logic [31:0] servo_pos_r;
  logic [15:0] servo_timer_r;

  // latch only while armed; source 0 and 3 latch counter in hardware
  assign hw_latch = trig_edge & ~captured_r &
                    ((cfg.capture_source_select ==
                      trigger_capture_pkg::SRC_HW) |
                     (cfg.capture_source_select ==
                      trigger_capture_pkg::SRC_TIMER_SW));
  assign timer_latch = trig_edge & ~captured_r;

  // trigger position latch, count and fraction of the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_r <= 32'h00000000;
    end else if (hw_latch) begin
      if (cfg.timer_extension_mode == 2'h0) begin
        latch_r <= {count_r, now_frac[11:4]};
      end else begin
        latch_r <= {count_r, trigger_capture_pkg::HALF_COUNT_FRAC};
      end
    end
  end

  // fine latch, filled only with timer extension mode 0
  always_ff @(posedge clk) begin
    if (rst) begin
      fine_r <= 32'h00000000;
    end else if (hw_latch && cfg.timer_extension_mode == 2'h0) begin
      fine_r <= {count_r[19:0], now_frac};
    end
  end

  // timer value at trigger, kept for every source
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_timer_r <= 16'h0000;
    end else if (timer_latch) begin
      trig_timer_r <= elapsed_r;
    end
  end

  // captured flag; a trigger wins over a re-arming read in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      captured_r <= 1'b0;
    end else if (timer_latch) begin
      captured_r <= 1'b1;
    end else if (latch_read) begin
      captured_r <= 1'b0;
    end
  end

  // servo interrupt edge latches position and timer
  always_ff @(posedge clk) begin
    if (rst) begin
      servo_prev_r <= 1'b0;
    end else begin
      servo_prev_r <= servo_int;
    end
  end
  assign servo_edge = rose(servo_int, servo_prev_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      servo_pos_r <= 32'h00000000;
      servo_timer_r <= 16'h0000;
    end else if (servo_edge) begin
      servo_timer_r <= elapsed_r;
      if (cfg.arctangent_enable) begin
        servo_pos_r <= {count_r[19:0], atan_frac};
      end else begin
        servo_pos_r <= {count_r[19:0], now_frac};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software capture lag watch

  logic sw_mode;
  logic [8:0] lag_cnt_r;
  logic overdue_r;

  assign sw_mode = (cfg.capture_source_select ==
                    trigger_capture_pkg::SRC_SW_INPUT) |
                   (cfg.capture_source_select ==
                    trigger_capture_pkg::SRC_SW_ERROR);

  // counts servo interrupts while an unread software capture waits
  always_ff @(posedge clk) begin
    if (rst) begin
      lag_cnt_r <= 9'h000;
      overdue_r <= 1'b0;
    end else if (!sw_mode || !captured_r || latch_read) begin
      lag_cnt_r <= 9'h000;
      overdue_r <= 1'b0;
    end else if (servo_edge && lag_cnt_r != 9'h1FF) begin
      lag_cnt_r <= lag_cnt_r + 9'h001;
      overdue_r <= (lag_cnt_r >=
                    {1'b0, cfg.realtime_interrupt_period});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // status word carries the captured indication only
  // follows the captured flag's next value, so a read clears it at once
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_status <= 32'h00000000;
    end else begin
      channel_status <= 32'h00000000;
      channel_status[trigger_capture_pkg::STATUS_CAPTURED_BIT] <=
        (captured_r & ~latch_read) | timer_latch;
    end
  end

  assign pulse_clock_divider = div_r;
  assign pulse_rate_command = rate_r;
  assign trigger_position_latch = latch_r;
  assign fine_trigger_capture = fine_r;
  assign servo_position = servo_pos_r;
  assign trigger_timer = trig_timer_r;
  assign servo_timer = servo_timer_r;
  assign sw_capture_overdue = overdue_r;
  assign pulse_out = pulse_r;

endmodule : trigger_position_capture

// ---- tb/trigger_capture_sva.sv ----
// Purpose: port checker for the trigger position capture unit
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the design from the testbench top file
`timescale 1ns/1ns
module trigger_capture_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs watched
  input wire trigger_capture_pkg::capture_cfg_t cfg,
  input wire logic [15:0] flags,
  input wire logic pulse_rate_we,
  input wire logic nv_valid,
  input wire logic [31:0] nv_pulse_rate,
  input wire logic latch_read,
  // outputs watched
  input wire logic [2:0] pulse_clock_divider,
  input wire logic [31:0] pulse_rate_command,
  input wire logic [31:0] trigger_position_latch,
  input wire logic [31:0] fine_trigger_capture,
  input wire logic [31:0] channel_status,
  input wire logic pulse_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////
  // selected flag level history
  logic [1:0] lvl_r;
  always_ff @(posedge clk) begin
    lvl_r <= {lvl_r[0], flags[{cfg.trigger_flag_channel,
                                cfg.trigger_flag_select}]};
  end
  // checks
  a_div_reset: assert property ($fell(rst) |-> pulse_clock_divider == 3'h5)
    else $error("divider reset value wrong");
  a_nv_load: assert property ($fell(rst) && nv_valid && !pulse_rate_we |=>
    pulse_rate_command == $past(nv_pulse_rate))
    else $error("stored command not loaded");
  a_pulse_single: assert property (pulse_out |=> !pulse_out [*7])
    else $error("pulse spacing too short");
  a_status_bits: assert property (channel_status[19:0] == 20'h0 &&
    channel_status[31:21] == 11'h0)
    else $error("stray status bit");
  a_captured_holds: assert property (channel_status[20] && !latch_read |=>
    channel_status[20])
    else $error("captured dropped without read");
  a_edge_only: assert property ($rose(channel_status[20]) &&
    $past(cfg.trigger_edge_select) == 4'h2 |-> lvl_r == 2'b01)
    else $error("capture without rising edge");
  a_half_frac: assert property ($changed(trigger_position_latch) &&
    $past(cfg.timer_extension_mode) != 2'h0 |->
    trigger_position_latch[7:0] == 8'h80)
    else $error("fraction not one half");
  a_sw_no_latch: assert property ($past(cfg.capture_source_select) inside
    {2'h1, 2'h2} |-> $stable(trigger_position_latch))
    else $error("software source moved latch");
  a_fine_mode: assert property ($changed(fine_trigger_capture) |->
    $past(cfg.timer_extension_mode) == 2'h0)
    else $error("fine latch written in wrong mode");
  a_pair_match: assert property ($changed(fine_trigger_capture) |->
    trigger_position_latch[27:8] == fine_trigger_capture[31:12] &&
    trigger_position_latch[7:0] == fine_trigger_capture[11:4])
    else $error("latch and fine disagree");
endmodule : trigger_capture_sva

// ---- tb/axis_model.sv ----
// Purpose: encoder and trigger flag lines of one motor axis
// Assumes: bench selects which flag carries the trigger level
// Notes: unselected flags and index come from a noise register shifted every cycle
`timescale 1ns/1ns
module axis_model (
  // clock
  input wire logic clk,
  // bench requests
  input wire logic run,
  input wire logic [3:0] flag_idx,
  input wire logic flag_lvl,
  // axis lines
  output logic enc_a,
  output logic enc_b,
  output logic enc_index,
  output logic [15:0] flags
);
  logic [1:0] ph_r = 2'h0;
  logic [15:0] noise_r = 16'hACE1;
  // quadrature walk and noise source
  always_ff @(posedge clk) begin
    if (run)
      ph_r <= ph_r + 2'h1;
    noise_r <= {noise_r[14:0],
                noise_r[15] ^ noise_r[13] ^ noise_r[12] ^ noise_r[10]};
  end
  // encoder and flags of the same axis
  assign enc_a = ph_r[1];
  assign enc_b = ph_r[1] ^ ph_r[0];
  assign enc_index = noise_r[3];
  always_comb begin
    flags = noise_r;
    flags[flag_idx] = flag_lvl;
  end
endmodule : axis_model

// ---- tb/trigger_position_capture_test.sv ----
// Purpose: self-checking bench for the trigger position capture unit
// Assumes: counter fed by internal pulses throughout
// Notes: random values from a fixed xorshift seed
`timescale 1ns/1ns
module trigger_position_capture_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  trigger_capture_pkg::capture_cfg_t cfg;
  logic div_we = 1'b0;
  logic [2:0] div_wdata = 3'h0;
  logic pulse_rate_we = 1'b0;
  logic [31:0] pulse_rate_wdata = 32'h0;
  logic nv_valid = 1'b1;
  logic [31:0] nv_pulse_rate;
  logic [11:0] atan_frac;
  logic servo_int = 1'b0;
  logic latch_read = 1'b0;
  logic run = 1'b1;
  logic [3:0] flag_idx = 4'h0;
  logic flag_lvl = 1'b0;
  logic enc_a, enc_b, enc_index;
  logic [15:0] flags;
  logic [2:0] pulse_clock_divider;
  logic [31:0] pulse_rate_command, trigger_position_latch;
  logic [31:0] fine_trigger_capture, servo_position, channel_status;
  logic [15:0] trigger_timer, servo_timer;
  logic sw_capture_overdue, pulse_out;
  int errors = 0;
  int total_checks = 0;
  int npulse = 0;
  logic [9:0] scnt = 10'h0;
  logic [31:0] seed = 32'h8;
  //////////////////////////////////////////////////////////////////////////
  // clock, pulse tally, servo interrupt every 512 cycles
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (pulse_out === 1'b1)
      npulse++;
    scnt <= scnt + 10'h1;
    servo_int <= (scnt[8:0] < 9'h020);
  end
  trigger_position_capture u_dut (.clk(clk), .rst(rst), .cfg(cfg),
    .div_we(div_we), .div_wdata(div_wdata),
    .pulse_clock_divider(pulse_clock_divider),
    .pulse_rate_we(pulse_rate_we), .pulse_rate_wdata(pulse_rate_wdata),
    .nv_valid(nv_valid), .nv_pulse_rate(nv_pulse_rate),
    .pulse_rate_command(pulse_rate_command), .enc_a(enc_a), .enc_b(enc_b),
    .enc_index(enc_index), .flags(flags), .atan_frac(atan_frac),
    .servo_int(servo_int), .latch_read(latch_read),
    .trigger_position_latch(trigger_position_latch),
    .fine_trigger_capture(fine_trigger_capture),
    .servo_position(servo_position), .trigger_timer(trigger_timer),
    .servo_timer(servo_timer), .channel_status(channel_status),
    .sw_capture_overdue(sw_capture_overdue), .pulse_out(pulse_out));
  axis_model u_axis (.clk(clk), .run(run), .flag_idx(flag_idx),
    .flag_lvl(flag_lvl), .enc_a(enc_a), .enc_b(enc_b),
    .enc_index(enc_index), .flags(flags));
  // helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wr(input logic div, input logic [31:0] v);
    @(posedge clk);
    div_we <= div;
    pulse_rate_we <= !div;
    div_wdata <= v[2:0];
    pulse_rate_wdata <= v;
    @(posedge clk);
    div_we <= 1'b0;
    pulse_rate_we <= 1'b0;
  endtask : wr
  task automatic final_report;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  // watchdog
  initial begin
    #(8 * 40000);
    errors++;
    final_report();
  end
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] c, old, oldf, snap;
    logic inv;
    longint unsigned lo, hi;
    int n;
    cfg = '0;
    cfg.counter_input_select = trigger_capture_pkg::CNT_SEL_PULSE;
    cfg.trigger_edge_select = 4'h2;
    cfg.arctangent_enable = 1'b1;
    cfg.realtime_interrupt_period = 8'h01;
    seed = xorshift(seed);
    nv_pulse_rate = seed;
    atan_frac = seed[23:12];
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    step(2);
    check(pulse_rate_command, nv_pulse_rate);
    check({29'h0, pulse_clock_divider}, 32'h5);
    check(channel_status, 32'h0);
    wr(1'b0, 32'h0);
    step(60);
    wr(1'b1, 32'h1);
    step(1);
    check({29'h0, pulse_clock_divider}, 32'h1);
    for (int k = 0; k < 3; k++) begin
      seed = xorshift(seed);
      c = {2'h0, seed[29:0]};
      wr(1'b0, c);
      step(8);
      n = npulse;
      step(800);
      n = npulse - n;
      lo = (longint'(c) * 99) >> 32;
      hi = ((longint'(c) * 101) >> 32) + 1;
      check({31'h0, n >= lo && n <= hi}, 32'h1);
    end
    wr(1'b0, 32'h40000000);
    step(1);
    check(pulse_rate_command, 32'h40000000);
    for (int i = 0; i < 5; i++) begin
      seed = xorshift(seed);
      inv = (i == 3);
      @(posedge clk);
      cfg.capture_source_select <= i[1:0];
      cfg.timer_extension_mode <= {1'b0, i == 4};
      cfg.trigger_flag_channel <= seed[3:2];
      cfg.trigger_flag_select <= seed[1:0];
      cfg.trigger_edge_select <= inv ? 4'hA : 4'h2;
      flag_idx <= seed[3:0];
      flag_lvl <= inv;
      step(40);
      old = trigger_position_latch;
      oldf = fine_trigger_capture;
      n = 0;
      while (pulse_out !== 1'b1 && n < 100) begin
        step(1);
        n++;
      end
      repeat (3) @(posedge clk);
      flag_lvl <= !inv;
      snap = 32'(npulse);
      step(2);
      check(channel_status, 32'h00100000);
      check({16'h0, trigger_timer}, 32'h2);
      if (i == 1 || i == 2) begin
        check(trigger_position_latch, old);
        check({31'h0, sw_capture_overdue}, 32'h0);
        step(1100);
        check({31'h0, sw_capture_overdue}, 32'h1);
      end else begin
        check(trigger_position_latch >> 8, {8'h0, snap[23:0]});
      end
      if (i == 4) begin
        check({24'h0, trigger_position_latch[7:0]}, 32'h80);
        check(fine_trigger_capture, oldf);
      end else if (i == 0 || i == 3) begin
        check(fine_trigger_capture >> 12, {12'h0, snap[19:0]});
        check({31'h0, trigger_position_latch[7:0] != 8'h0 &&
               trigger_position_latch[7:0] < 8'h40}, 32'h1);
      end
      @(posedge clk);
      latch_read <= 1'b1;
      @(posedge clk);
      latch_read <= 1'b0;
      step(6);
      check(channel_status, 32'h0);
      check({31'h0, sw_capture_overdue}, 32'h0);
      @(posedge clk);
      flag_lvl <= inv;
    end
    n = 0;
    while (servo_int !== 1'b1 && n < 600) begin
      step(1);
      n++;
    end
    step(2);
    check({20'h0, servo_position[11:0]}, {20'h0, atan_frac});
    check({31'h0, servo_timer < 16'h0020}, 32'h1);
    final_report();
  end
endmodule : trigger_position_capture_test
bind trigger_position_capture trigger_capture_sva u_sva (.clk(clk),
  .rst(rst), .cfg(cfg), .flags(flags), .pulse_rate_we(pulse_rate_we),
  .nv_valid(nv_valid), .nv_pulse_rate(nv_pulse_rate),
  .latch_read(latch_read), .pulse_clock_divider(pulse_clock_divider),
  .pulse_rate_command(pulse_rate_command),
  .trigger_position_latch(trigger_position_latch),
  .fine_trigger_capture(fine_trigger_capture),
  .channel_status(channel_status), .pulse_out(pulse_out));
